// [mrh_top.sv]
/*
 * Motion relay hold timer: turns engine motion events into a timed relay
 * on-period, with short first hold, late detection, test timings, light
 * gate and an AHB-Lite register file.
 * Assumes all inputs synchronous to mclk and a single AHB-Lite master.
 */
// Added by the designer: the register offsets and the AHB-Lite register port.
// Function
// [R1] run conversions nonstop, strobe every 256 clocks, hand sample to engine
// [R2] 100 ms tick advances hold timers and turns the relay off at expiry
// [R3] derive one-second timebase flag from the tick for the engine
// [R4] short first hold has an enable bit, default on
// [R5] short first hold only when selected hold at least minimum, default 20 s
// [R6] first events until count reached load the short hold, default 10 s
// [R7] after the event count, default 3, switch to the full selected hold
// [R8] late detection has an enable bit, default on
// [R9] holds at or above threshold use fixed window, shorter use half hold
// [R10] with late detection ignore motion until only the window remains
// [R11] lens test: 2 s for normal detector, 5 s for extended detector
// [R12] noise test: 1 s for transient, 0.5 s for noise
// [R13] lens test and noise test should not be enabled together
// [R14] light below gate level blocks engagement, equal or above permits it
// [R15] hold chosen from 16-entry writable table, 2 s to 5 min default
// [R16] lowest delay pot reading selects the first, longest entry
// [R17] last two entries of hold and sensitivity tables are equal
// [R18] sensitivity reading shifted down to a 4-bit index, 16 levels
// [R19] index zero is lowest pot voltage and most sensitive setting
// [R20] each level sets detector gain, range field and extended level
// [R21] extended level logarithmic, off before midpoint; range linear
// [R22] sensitivity settings refreshed continuously from the pot
// [R23] accepted motion while on reloads the hold counter
`timescale 1ns/10ps
`default_nettype none
module mrh_top #(
   parameter int ADC_W = 8,
   parameter int TICK_CYC = mrh_pkg::TICK_CYC
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // converter readings
   input wire logic [ADC_W-1:0] pir_adc,
   input wire logic [ADC_W-1:0] delay_pot_adc,
   input wire logic [ADC_W-1:0] sense_pot_adc,
   input wire logic [ADC_W-1:0] light_adc,
   // motion engine
   input wire logic motion_normal,
   input wire logic motion_extended,
   input wire logic noise_flag,
   input wire logic transient_flag,
   output logic conv_evt,
   output logic [ADC_W-1:0] engine_sample,
   output logic timebase_flag,
   output logic [7:0] normal_detector_gain,
   output logic [3:0] engine_control_two_range,
   output logic [1:0] engine_control_zero_ext,
   // relay driver
   output logic relay_on
);

   // ---------------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------------
   logic conv_raw;
   logic tick;
   logic [7:0] addr_q;
   logic wr_q;
   logic rd_q;
   logic [31:0] rdata_d;
   logic [3:0] ctrl_q;
   logic [15:0] short_hold_min_setting_q;
   logic [15:0] short_time_q;
   logic [3:0] short_count_q;
   logic [15:0] late_th_q;
   logic [15:0] late_win_q;
   logic [ADC_W-1:0] ambient_gate_level_q;
   logic [15:0] hold_tab_q [16];
   mrh_pkg::mrh_state_type st_q;
   mrh_pkg::mrh_state_type st_d;
   logic [15:0] hold_q;
   logic [15:0] hold_d;
   logic [3:0] ecnt_q;
   logic [3:0] ecnt_d;
   logic [3:0] dly_idx;
   logic [15:0] sel_hold;
   logic [15:0] window;
   logic [15:0] load;
   logic test_lens;
   logic test_noise;
   logic light_ok;
   logic short_ok;
   logic late_block;
   logic motion;
   logic evt;

   // ---------------------------------------------------------------------
   // timebase and sensitivity
   // ---------------------------------------------------------------------
   mrh_tick_gen #(
      .TICK_CYC(TICK_CYC)
   ) u_tick (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .conv_evt(conv_raw),
      .tick(tick),
      .sec_flag(timebase_flag)
   );

   mrh_sense_map #(
      .ADC_W(ADC_W)
   ) u_sense (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .conv_evt(conv_raw),
      .sense_adc(sense_pot_adc),
      .gain(normal_detector_gain),
      .range(engine_control_two_range),
      .ext(engine_control_zero_ext)
   );

   // sample hand-over to the engine
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         conv_evt <= 1'b0;
         engine_sample <= '0;
      end else if (ce) begin
         conv_evt <= conv_raw; // R1
         if (conv_raw) begin
            engine_sample <= pir_adc; // R1
         end
      end
   end

   // ---------------------------------------------------------------------
   // ahb-lite slave, zero-wait writes, one-wait reads
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else if (ce) begin
         wr_q <= 1'b0;
         hresp <= 1'b0;
         if (rd_q) begin
            hrdata <= rdata_d;
            rd_q <= 1'b0;
            hreadyout <= 1'b1;
         end else if (hsel && htrans[1] && hready) begin
            addr_q <= haddr[7:0];
            wr_q <= hwrite;
            rd_q <= !hwrite;
            hreadyout <= hwrite;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_q <= mrh_pkg::CTRL_RST; // R4 R8
         short_hold_min_setting_q <= mrh_pkg::SHORT_MIN_TK;
         short_time_q <= mrh_pkg::SHORT_TIME_TK;
         short_count_q <= mrh_pkg::SHORT_COUNT_RST;
         late_th_q <= mrh_pkg::LATE_TH_TK;
         late_win_q <= mrh_pkg::LATE_WIN_TK;
         ambient_gate_level_q <= ADC_W'(mrh_pkg::AMBIENT_RST);
         for (int i = 0; i < 16; i++) begin
            hold_tab_q[i] <= mrh_pkg::HOLD_RST[i]; // R15 R17
         end
      end else if (ce && wr_q) begin
         case (addr_q)
            mrh_pkg::OFS_CTRL: ctrl_q <= hwdata[3:0];
            mrh_pkg::OFS_SHORT_MIN: short_hold_min_setting_q <= hwdata[15:0];
            mrh_pkg::OFS_SHORT_TIME: short_time_q <= hwdata[15:0];
            mrh_pkg::OFS_SHORT_COUNT: short_count_q <= hwdata[3:0];
            mrh_pkg::OFS_LATE_TH: late_th_q <= hwdata[15:0];
            mrh_pkg::OFS_LATE_WIN: late_win_q <= hwdata[15:0];
            mrh_pkg::OFS_AMBIENT: ambient_gate_level_q <= hwdata[ADC_W-1:0];
            default: begin
               if (addr_q[7:6] == mrh_pkg::HOLD_TAB_PAGE) begin
                  hold_tab_q[addr_q[5:2]] <= hwdata[15:0]; // R15
               end
            end
         endcase
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      case (addr_q)
         mrh_pkg::OFS_CTRL: rdata_d[3:0] = ctrl_q;
         mrh_pkg::OFS_SHORT_MIN: rdata_d[15:0] = short_hold_min_setting_q;
         mrh_pkg::OFS_SHORT_TIME: rdata_d[15:0] = short_time_q;
         mrh_pkg::OFS_SHORT_COUNT: rdata_d[3:0] = short_count_q;
         mrh_pkg::OFS_LATE_TH: rdata_d[15:0] = late_th_q;
         mrh_pkg::OFS_LATE_WIN: rdata_d[15:0] = late_win_q;
         mrh_pkg::OFS_AMBIENT: rdata_d[ADC_W-1:0] = ambient_gate_level_q;
         mrh_pkg::OFS_STATUS: begin
            rdata_d[mrh_pkg::STAT_RELAY] = relay_on;
            rdata_d[mrh_pkg::STAT_SHORT] = (st_q == mrh_pkg::MRH_SHORT);
            rdata_d[mrh_pkg::STAT_ECNT +: 4] = ecnt_q;
            rdata_d[mrh_pkg::STAT_HOLD +: 16] = hold_q;
         end
         default: begin
            if (addr_q[7:6] == mrh_pkg::HOLD_TAB_PAGE) begin
               rdata_d[15:0] = hold_tab_q[addr_q[5:2]];
            end
         end
      endcase
   end

   // ---------------------------------------------------------------------
   // hold selection and gates
   // ---------------------------------------------------------------------
   assign dly_idx = mrh_pkg::pot_idx(16'(delay_pot_adc), ADC_W); // R16
   assign sel_hold = hold_tab_q[dly_idx]; // R15 R16
   assign motion = motion_normal | motion_extended;
   assign test_lens = ctrl_q[mrh_pkg::CTRL_LENS];
   assign test_noise = ctrl_q[mrh_pkg::CTRL_NOISE] & !test_lens; // R13
   assign light_ok = (light_adc >= ambient_gate_level_q); // R14
   assign short_ok = ctrl_q[mrh_pkg::CTRL_SHORT_EN] & !test_lens & !test_noise // R4
      & (sel_hold >= short_hold_min_setting_q); // R5
   assign window = (sel_hold >= late_th_q) ? late_win_q : (sel_hold >> 1); // R9
   assign late_block = ctrl_q[mrh_pkg::CTRL_LATE_EN] & !test_lens & !test_noise // R8
      & (st_q != mrh_pkg::MRH_OFF) & (hold_q > window); // R10

   // ---------------------------------------------------------------------
   // hold state machine
   // ---------------------------------------------------------------------
   always_comb begin
      evt = 1'b0;
      load = sel_hold;
      st_d = st_q;
      ecnt_d = ecnt_q;
      hold_d = hold_q;
      if (tick && hold_q != 16'h0000) begin
         hold_d = hold_q - 16'h0001; // R2
      end
      if (test_lens) begin
         evt = motion;
         load = motion_extended ? mrh_pkg::LENS_EXT_TK : mrh_pkg::LENS_NORM_TK; // R11
      end else if (test_noise) begin
         evt = transient_flag | noise_flag;
         load = transient_flag ? mrh_pkg::NOISE_TRANS_TK : mrh_pkg::NOISE_NOISE_TK; // R12
      end else begin
         evt = motion & !late_block; // R10
      end
      if (st_q == mrh_pkg::MRH_OFF && !light_ok) begin
         evt = 1'b0; // R14
      end
      if (evt) begin
         unique case (st_q)
            mrh_pkg::MRH_OFF: begin
               ecnt_d = 4'h1;
               if (short_ok && short_count_q > 4'h1) begin
                  st_d = mrh_pkg::MRH_SHORT;
                  load = short_time_q; // R6
               end else begin
                  st_d = mrh_pkg::MRH_FULL; // R5
               end
            end
            mrh_pkg::MRH_SHORT: begin
               ecnt_d = ecnt_q + 4'h1;
               if ({1'b0, ecnt_q} + 5'h01 >= {1'b0, short_count_q}) begin
                  st_d = mrh_pkg::MRH_FULL; // R7
               end else begin
                  load = short_time_q; // R6
               end
            end
            mrh_pkg::MRH_FULL: begin
               st_d = mrh_pkg::MRH_FULL;
            end
            default: begin
               st_d = mrh_pkg::MRH_OFF;
            end
         endcase
         hold_d = load; // R23
      end
      if (hold_d == 16'h0000) begin
         st_d = mrh_pkg::MRH_OFF; // R2
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q <= mrh_pkg::MRH_OFF;
         hold_q <= 16'h0000;
         ecnt_q <= 4'h0;
         relay_on <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         hold_q <= hold_d;
         ecnt_q <= ecnt_d;
         relay_on <= (hold_d != 16'h0000); // R2
      end
   end

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_engage;
      ce && st_q == mrh_pkg::MRH_OFF && evt;
   endsequence

   sequence s_count_hit;
      ce && st_q == mrh_pkg::MRH_SHORT && evt && ({1'b0, ecnt_q} + 5'h01 >= {1'b0, short_count_q});
   endsequence

   AST_RELAY_EXPIRE: assert property ( // R2
      ce && tick && hold_q == 16'h0001 && !evt |=> !relay_on && st_q == mrh_pkg::MRH_OFF)
      else $error("relay not released at hold expiry");

   AST_DARK_BLOCK: assert property ( // R14
      ce && st_q == mrh_pkg::MRH_OFF && !light_ok |=> !relay_on)
      else $error("relay engaged below light gate");

   AST_LENS_EXT: assert property ( // R11
      ce && test_lens && motion_extended && light_ok |=> relay_on && hold_q == mrh_pkg::LENS_EXT_TK)
      else $error("lens test extended hold wrong");

   AST_NOISE_TRANS: assert property ( // R12
      ce && test_noise && transient_flag && light_ok |=> hold_q == mrh_pkg::NOISE_TRANS_TK)
      else $error("noise test transient hold wrong");

   AST_SHORT_LOAD: assert property ( // R6
      s_engage ##0 short_ok && short_count_q > 4'h1
      |=> st_q == mrh_pkg::MRH_SHORT && hold_q == $past(short_time_q))
      else $error("short first hold not loaded");

   AST_SHORT_MIN: assert property ( // R5
      s_engage ##0 !short_ok && !test_lens && !test_noise
      |=> st_q == mrh_pkg::MRH_FULL && hold_q == $past(sel_hold))
      else $error("short hold used below its minimum");

   AST_FULL_AFTER: assert property ( // R7
      s_count_hit |=> st_q == mrh_pkg::MRH_FULL && hold_q == $past(sel_hold))
      else $error("full hold not taken after event count");

   AST_LATE_IGNORE: assert property ( // R10
      ce && late_block && motion |=> hold_q <= $past(hold_q))
      else $error("motion acted on outside late window");

   AST_RETRIGGER: assert property ( // R23
      ce && st_q == mrh_pkg::MRH_FULL && evt |=> relay_on && hold_q == $past(load))
      else $error("hold not reloaded on retrigger");

endmodule : mrh_top
`default_nettype wire

// [mrh_pkg.sv]
/*
 * Constants, types and small helpers shared by the motion relay hold timer.
 * Assumes a 20 MHz system clock and potentiometer readings of up to 16 bits.
 */
`default_nettype none
package mrh_pkg;

   // ---------------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int CONV_CYC = 256;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_S = 1000 / TICK_MS;

   // hold figures in their own units
   localparam int SHORT_MIN_S = 20;
   localparam int SHORT_TIME_S = 10;
   localparam int SHORT_COUNT = 3;
   localparam int LATE_TH_MIN = 5;
   localparam int LATE_WIN_MIN = 1;
   localparam int LENS_NORM_S = 2;
   localparam int LENS_EXT_S = 5;
   localparam int NOISE_TRANS_MS = 1000;
   localparam int NOISE_NOISE_MS = 500;

   // same figures in ticks, event count kept as a plain count
   localparam logic [15:0] SHORT_MIN_TK = 16'(SHORT_MIN_S * 1000 / TICK_MS);
   localparam logic [15:0] SHORT_TIME_TK = 16'(SHORT_TIME_S * 1000 / TICK_MS);
   localparam logic [3:0] SHORT_COUNT_RST = 4'(SHORT_COUNT);
   localparam logic [15:0] LATE_TH_TK = 16'(LATE_TH_MIN * 60 * 1000 / TICK_MS);
   localparam logic [15:0] LATE_WIN_TK = 16'(LATE_WIN_MIN * 60 * 1000 / TICK_MS);
   localparam logic [15:0] LENS_NORM_TK = 16'(LENS_NORM_S * 1000 / TICK_MS);
   localparam logic [15:0] LENS_EXT_TK = 16'(LENS_EXT_S * 1000 / TICK_MS);
   localparam logic [15:0] NOISE_TRANS_TK = 16'(NOISE_TRANS_MS / TICK_MS);
   localparam logic [15:0] NOISE_NOISE_TK = 16'(NOISE_NOISE_MS / TICK_MS);

   // ---------------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SHORT_MIN = 8'h04;
   localparam logic [7:0] OFS_SHORT_TIME = 8'h08;
   localparam logic [7:0] OFS_SHORT_COUNT = 8'h0C;
   localparam logic [7:0] OFS_LATE_TH = 8'h10;
   localparam logic [7:0] OFS_LATE_WIN = 8'h14;
   localparam logic [7:0] OFS_AMBIENT = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [1:0] HOLD_TAB_PAGE = 2'h1;

   localparam int CTRL_SHORT_EN = 0;
   localparam int CTRL_LATE_EN = 1;
   localparam int CTRL_LENS = 2;
   localparam int CTRL_NOISE = 3;
   localparam logic [3:0] CTRL_RST = 4'h3;
   localparam logic [7:0] AMBIENT_RST = 8'h40;

   localparam int STAT_RELAY = 0;
   localparam int STAT_SHORT = 1;
   localparam int STAT_ECNT = 4;
   localparam int STAT_HOLD = 16;

   // hold table in ticks, longest first, last two equal
   localparam logic [15:0] HOLD_RST [16] = '{
      16'h0BB8, 16'h0960, 16'h0708, 16'h04B0, 16'h0384, 16'h0258, 16'h01C2, 16'h012C,
      16'h00C8, 16'h0096, 16'h0064, 16'h003C, 16'h0028, 16'h001E, 16'h0014, 16'h0014
   };

   localparam logic [3:0] SENSE_EXT_OFF = 4'h7;

   typedef enum logic [1:0] {
      MRH_OFF = 2'b00,
      MRH_SHORT = 2'b01,
      MRH_FULL = 2'b10
   } mrh_state_type;

   // reduce a pot reading to a 4-bit index
   function automatic logic [3:0] pot_idx(input logic [15:0] raw, input int w);
      return 4'(raw >> (w - 4));
   endfunction : pot_idx

endpackage : mrh_pkg
`default_nettype wire

// [mrh_tick_gen.sv]
/*
 * Conversion strobe, 100 ms tick and one-second timebase.
 * Assumes one system clock and a clock enable that freezes all counters.
 */
`timescale 1ns/10ps
`default_nettype none
module mrh_tick_gen #(
   parameter int TICK_CYC = mrh_pkg::TICK_CYC
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // strobes
   output logic conv_evt,
   output logic tick,
   output logic sec_flag
);
   localparam int CW = $clog2(mrh_pkg::CONV_CYC);
   localparam int TW = $clog2(TICK_CYC);

   logic [CW-1:0] conv_q;
   logic [TW-1:0] tick_q;
   logic [3:0] sec_q;
   logic [CW-1:0] gap_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         conv_q <= '0;
         conv_evt <= 1'b0;
      end else if (ce) begin
         conv_q <= conv_q + 1'b1;
         conv_evt <= (conv_q == CW'(mrh_pkg::CONV_CYC - 1)); // R1
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tick_q <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         tick <= (tick_q == TW'(TICK_CYC - 1)); // R2
         tick_q <= (tick_q == TW'(TICK_CYC - 1)) ? '0 : tick_q + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sec_q <= 4'h0;
         sec_flag <= 1'b0;
      end else if (ce) begin
         sec_flag <= tick && (sec_q == 4'(mrh_pkg::TICKS_PER_S - 1)); // R3
         if (tick) begin
            sec_q <= (sec_q == 4'(mrh_pkg::TICKS_PER_S - 1)) ? 4'h0 : sec_q + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gap_q <= '1;
      end else if (ce) begin
         gap_q <= conv_evt ? '0 : gap_q + 1'b1;
      end
   end

   AST_CONV_PERIOD: assert property (@(posedge mclk) disable iff (!rst_n) // R1
      conv_evt |-> gap_q == CW'(mrh_pkg::CONV_CYC - 1))
      else $error("conversion strobe off its period");

   AST_SEC_FROM_TICK: assert property (@(posedge mclk) disable iff (!rst_n) // R3
      $rose(sec_flag) |-> $past(tick) && $past(ce))
      else $error("timebase flag not tied to a tick");

endmodule : mrh_tick_gen
`default_nettype wire

// [mrh_sense_map.sv]
/*
 * Sensitivity pot to detector settings lookup, refreshed every conversion.
 * Assumes the pot reading is synchronous and ADC_W is at least 4.
 */
`timescale 1ns/10ps
`default_nettype none
module mrh_sense_map #(
   parameter int ADC_W = 8
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // sample
   input wire logic conv_evt,
   input wire logic [ADC_W-1:0] sense_adc,
   // engine settings
   output logic [7:0] gain,
   output logic [3:0] range,
   output logic [1:0] ext
);
   logic [3:0] idx;

   // gain semilog, range linear, extended level log
   function automatic logic [13:0] sense_entry(input logic [3:0] k);
      logic [3:0] i;
      logic [7:0] g;
      logic [1:0] e;
      i = (k == 4'hF) ? 4'hE : k; // R17
      g = 8'(((9'h002 + {8'h00, i[0]}) << i[3:1]) >> 1); // R20
      e = (i == 4'h0) ? 2'h3 : (i < 4'h3) ? 2'h2 : (i < mrh_pkg::SENSE_EXT_OFF) ? 2'h1 : 2'h0;
      return {g, i, e}; // R20
   endfunction : sense_entry

   assign idx = mrh_pkg::pot_idx(16'(sense_adc), ADC_W); // R18 R19

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         {gain, range, ext} <= sense_entry(4'h0);
      end else if (ce && conv_evt) begin
         {gain, range, ext} <= sense_entry(idx); // R22
      end
   end

   AST_EXT_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // R21
      ce && conv_evt && idx >= mrh_pkg::SENSE_EXT_OFF |=> ext == 2'h0)
      else $error("extended detector still on past its cutoff");

   AST_SENSE_TOP: assert property (@(posedge mclk) disable iff (!rst_n) // R17
      ce && conv_evt && idx == 4'hF |=> range == 4'hE && gain == 8'h80)
      else $error("last two sensitivity entries differ");

endmodule : mrh_sense_map
`default_nettype wire

// [mrh_far_model.sv]
/* far side stand-in: motion engine flags, sensor samples.
   assumes requests from the bench right after rising edges. */
`timescale 1ns/10ps
`default_nettype none
module mrh_far_model (
   // clock and requests
   input wire logic mclk,
   input wire logic conv_evt,
   input wire logic [3:0] req,
   // engine side
   output logic [7:0] pir_adc,
   output logic [3:0] flags
);
   initial pir_adc = 8'h5A;
   initial flags = 4'h0;
   // one-cycle flags, new sample each conversion
   always @(posedge mclk) begin
      flags <= req;
      if (conv_evt)
         pir_adc <= ~pir_adc + 8'h03;
   end
endmodule : mrh_far_model
`default_nettype wire

// [tb.sv]
/* tb: self-checking bench for the motion relay hold timer.
   assumes mrh_pkg, mrh_top and mrh_far_model compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int TC = 20;
   logic mclk = 1'h0, rst_n = 1'h0, ce = 1'h1, hsel = 1'h0, hwrite = 1'h0;
   logic hrdy, hresp, conv, tbf, relay;
   logic [1:0] htrans = 2'h0, ext;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [7:0] pir, dpot = 8'h0, spot = 8'h0, light = 8'hFF, smp, gain;
   logic [3:0] req = 4'h0, flg, rng;
   int n_mismatch = 0, compares = 0, n;
   mrh_top #(.ADC_W(8), .TICK_CYC(TC)) u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp),
      .pir_adc(pir), .delay_pot_adc(dpot), .sense_pot_adc(spot), .light_adc(light),
      .motion_normal(flg[0]), .motion_extended(flg[1]), .noise_flag(flg[2]),
      .transient_flag(flg[3]), .conv_evt(conv), .engine_sample(smp), .timebase_flag(tbf),
      .normal_detector_gain(gain), .engine_control_two_range(rng),
      .engine_control_zero_ext(ext), .relay_on(relay));
   mrh_far_model u_far (.mclk(mclk), .conv_evt(conv), .req(req), .pir_adc(pir), .flags(flg));
   initial forever #25 mclk = ~mclk;
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic hw();
      do @(negedge mclk); while (hrdy !== 1'b1);
      rd = hrdata;
      @(posedge mclk);
   endtask : hw
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      hw();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      hw();
   endtask : bus
   function automatic logic sig(input int w);
      return w == 0 ? conv : w == 1 ? tbf : relay;
   endfunction : sig
   task automatic span(input int w, input logic lv);
      n = 0;
      do begin n++; @(negedge mclk); end while (sig(w) !== lv);
   endtask : span
   task automatic fire(input int i);
      req <= 4'h1 << i;
      @(posedge mclk);
      req <= 4'h0;
      repeat (3) @(posedge mclk);
   endtask : fire
   task automatic timed(input int i, input int t);
      fire(i);
      span(2, 1'b0);
      @(posedge mclk);
      chk("on_time", 32'(n + 1 > (t - 1) * TC && n + 1 <= t * TC), 32'h1);
   endtask : timed
   task automatic hold(input int lo, input int hi);
      bus(1'b0, 8'h1C, 32'h0);
      chk("hold", 32'(rd[31:16] >= lo && rd[31:16] <= hi), 32'h1);
   endtask : hold
   task automatic two_conv();
      span(0, 1'b1);
      span(0, 1'b1);
      @(posedge mclk);
   endtask : two_conv
   task automatic t_regs();
      logic [7:0] a [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h40, 8'h78, 8'h7C, 8'h20};
      logic [31:0] v [9] = '{32'h3, 32'hC8, 32'h64, 32'h3, 32'h40, 32'hBB8, 32'h14, 32'h14, 32'h0};
      for (int k = 0; k < 9; k++) begin
         bus(1'b0, a[k], 32'h0);
         chk("reg", rd, v[k]);
         chk("resp", hresp, 1'b0);
      end
   endtask : t_regs
   task automatic t_sense();
      logic [13:0] s;
      spot <= 8'h0F;
      two_conv();
      chk("ext_low", ext, 2'h3);
      spot <= 8'h70;
      two_conv();
      chk("ext_mid", ext, 2'h0);
      chk("range_mid", rng, 4'h7);
      spot <= 8'hE0;
      two_conv();
      s = {gain, rng, ext};
      spot <= 8'hF0;
      two_conv();
      chk("sense_end", {gain, rng, ext}, s);
   endtask : t_sense
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_regs();
      span(0, 1'b1);
      span(0, 1'b1);
      chk("conv_gap", n, 256);
      chk("sample", smp, pir);
      span(1, 1'b1);
      span(1, 1'b1);
      chk("sec_gap", n, 10 * TC);
      @(posedge mclk);
      t_sense();
      bus(1'b1, 8'h00, 32'h0);
      dpot <= 8'hF0;
      light <= 8'h3F;
      fire(0);
      chk("gate", relay, 1'b0);
      light <= 8'h40;
      timed(0, 20);
      bus(1'b1, 8'h00, 32'h4);
      timed(0, 20);
      timed(1, 50);
      bus(1'b1, 8'h00, 32'h8);
      timed(3, 10);
      timed(2, 5);
      bus(1'b1, 8'h00, 32'hC);
      timed(1, 50);
      bus(1'b1, 8'h00, 32'h1);
      dpot <= 8'h00;
      bus(1'b1, 8'h40, 32'h12C);
      fire(0);
      hold(95, 100);
      fire(0);
      hold(95, 100);
      fire(0);
      hold(290, 300);
      span(2, 1'b0);
      @(posedge mclk);
      bus(1'b1, 8'h40, 32'h96);
      fire(0);
      hold(140, 150);
      span(2, 1'b0);
      @(posedge mclk);
      bus(1'b1, 8'h00, 32'h2);
      bus(1'b1, 8'h40, 32'h12C);
      bus(1'b1, 8'h14, 32'h64);
      for (int k = 0; k < 2; k++) begin
         fire(0);
         repeat (170 * TC) @(posedge mclk);
         fire(0);
         if (k == 0)
            hold(290, 300);
         else
            hold(115, 135);
         span(2, 1'b0);
         @(posedge mclk);
         bus(1'b1, 8'h10, 32'hC8);
      end
      finish_test();
   end
   initial begin
      #(60000 * 50);
      n_mismatch++;
      finish_test();
   end
   task automatic finish_test();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
endmodule : tb
`default_nettype wire
